// ### hw/dpsc_pkg.sv
// constants and types of the serial command port
package dpsc_pkg;
  // ------------------------------------------------------------
  // command word layout
  // ------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int CTL_HI = 15;
  localparam int CTL_LO = 12;
  localparam int ADR_HI = 11;
  localparam int ADR_LO = 8;
  localparam int DAT_HI = 7;
  localparam int DAT_LO = 0;
  localparam int BCAST_BIT = 3;
  localparam int CHSEL_BIT = 0;
  localparam int MEMSEL_BIT = 1;
  localparam int LSB_OPT_BIT = 0;
  // ------------------------------------------------------------
  // control nibbles
  // ------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] CMD_WR_INPUT = 4'h2;
  localparam logic [3:0] CMD_READBACK = 4'h3;
  localparam logic [3:0] CMD_COPY = 4'h7;
  localparam logic [3:0] CMD_SW_RESET = 4'hb;
  localparam logic [3:0] CMD_SHUTDOWN = 4'hc;
  // readback selectors on the two low data bits
  localparam logic [1:0] RB_INPUT = 2'h0;
  localparam logic [1:0] RB_EEPROM = 2'h1;
  localparam logic [1:0] RB_CONTROL = 2'h2;
  localparam logic [1:0] RB_WIPER = 2'h3;
  // ------------------------------------------------------------
  // frame length checks
  // ------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_MIN = 6'h10;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h20;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h3f;
  localparam int CNT_GRAN_BITS = 3;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int STORE_TIME_US = 15000;
  localparam int STORE_CYCLES = STORE_TIME_US * (CLK_HZ / 1000000);
  localparam int STORE_CNT_W = 20;
  // ------------------------------------------------------------
  // reset values and register port
  // ------------------------------------------------------------
  localparam logic [7:0] EEPROM_INIT = 8'h80;
  localparam int RADDR_W = 3;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_WIPER0 = 3'h2;
  localparam logic [2:0] REG_WIPER1 = 3'h3;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam int CTRL_EN_BIT = 0;
  typedef enum logic [0:0] {
    DPSC_ST_IDLE = 1'b0,
    DPSC_ST_STORE = 1'b1
  } dpsc_store_t;
endpackage

// ### hw/dpsc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module dpsc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ### hw/dpsc_port.sv
// serial command port of a dual-channel digital potentiometer
`timescale 1ns/100ps
module dpsc_port import dpsc_pkg::*; #(
  parameter int NCH = 2,
  parameter int STORE_CNT = STORE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_in,
  output logic serial_out_od,
  output logic serial_out_oe,
  input wire logic [RADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [NCH*8-1:0] wiper_setting,
  output logic [NCH-1:0] shutdown,
  output logic store_busy
);
  // ------------------------------------------------------------
  // pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [2:0] pin_q;
  logic frame_n_s;
  logic sclk_s;
  logic sdi_s;
  logic frame_n_d_r;
  logic sclk_d_r;
  logic frame_start;
  logic frame_end;
  logic sclk_fall;
  logic sclk_rise;

  dpsc_sync #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d({frame_sel_n, sclk, serial_in}),
    .q(pin_q)
  );

  assign frame_n_s = pin_q[2];
  assign sclk_s = pin_q[1];
  assign sdi_s = pin_q[0];

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      frame_n_d_r <= 1'b1;
      sclk_d_r <= 1'b1;
    end else begin
      frame_n_d_r <= frame_n_s;
      sclk_d_r <= sclk_s;
    end
  end

  assign frame_start = frame_n_d_r && !frame_n_s;
  assign frame_end = !frame_n_d_r && frame_n_s;
  assign sclk_fall = sclk_d_r && !sclk_s && !frame_n_s;
  assign sclk_rise = !sclk_d_r && sclk_s && !frame_n_s;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic [NCH-1:0] chan_mask(input logic [3:0] adr);
    logic [NCH-1:0] m;
    m = '0;
    if (adr[BCAST_BIT]) begin
      m = '1;
    end else begin
      m[adr[CHSEL_BIT]] = 1'b1;
    end
    return m;
  endfunction

  function automatic logic frame_len_ok(input logic [CNT_W-1:0] c);
    return (c >= CNT_MIN) && (c <= CNT_MAX) &&
           (c[CNT_GRAN_BITS-1:0] == '0);
  endfunction

  function automatic logic is_store(input logic [3:0] ctl, input logic opt);
    return (ctl == CMD_COPY) && opt;
  endfunction

  // ------------------------------------------------------------
  // falling edge counter
  // ------------------------------------------------------------
  logic [CNT_W-1:0] fall_cnt_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fall_cnt_r <= '0;
    end else if (frame_n_s) begin
      fall_cnt_r <= '0;
    end else if (sclk_fall && fall_cnt_r != CNT_SAT) begin
      fall_cnt_r <= fall_cnt_r + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // command word fields and execute strobe
  // ------------------------------------------------------------
  logic [WORD_W-1:0] shift_r;
  logic [7:0] ctrl_r;
  logic [3:0] cmd_ctl;
  logic [3:0] cmd_adr;
  logic [7:0] cmd_dat;
  logic [NCH-1:0] cmd_mask;
  logic cmd_opt;
  logic exec;
  logic store_go;
  dpsc_store_t store_st_r;

  assign cmd_ctl = shift_r[CTL_HI:CTL_LO];
  assign cmd_adr = shift_r[ADR_HI:ADR_LO];
  assign cmd_dat = shift_r[DAT_HI:DAT_LO];
  assign cmd_opt = cmd_dat[LSB_OPT_BIT];
  assign cmd_mask = chan_mask(cmd_adr);
  // decode only on frame select rise, with a valid count, the enable bit set and no store running
  assign exec = frame_end && frame_len_ok(fall_cnt_r) &&
                (store_st_r == DPSC_ST_IDLE) && ctrl_r[CTRL_EN_BIT];
  assign store_go = exec && is_store(cmd_ctl, cmd_opt);

  // ------------------------------------------------------------
  // channel storage
  // ------------------------------------------------------------
  logic [7:0] wiper_r [NCH];
  logic [7:0] input_r [NCH];
  logic [7:0] eeprom_r [NCH];
  logic [NCH-1:0] shdn_r;
  logic [7:0] rb_val;

  // readback source select
  always_comb begin
    logic eesel;
    logic chsel;
    eesel = cmd_adr[MEMSEL_BIT] | cmd_adr[CHSEL_BIT];
    chsel = cmd_adr[CHSEL_BIT];
    case (cmd_dat[1:0])
      RB_EEPROM: rb_val = eeprom_r[eesel];
      RB_WIPER: rb_val = wiper_r[chsel];
      RB_CONTROL: rb_val = {{(8-NCH){1'b0}}, shdn_r};
      RB_INPUT: rb_val = input_r[chsel];
      default: rb_val = '0;
    endcase
  end

  // ------------------------------------------------------------
  // input shift register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= '0;
    end else if (exec && cmd_ctl == CMD_READBACK) begin
      shift_r <= {8'h00, rb_val};
    end else if (sclk_fall) begin
      shift_r <= {shift_r[WORD_W-2:0], sdi_s};
    end
  end

  // ------------------------------------------------------------
  // open-drain serial output
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      serial_out_od <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_od <= 1'b0;
      if (frame_n_s) begin
        serial_out_oe <= 1'b0;
      end else if (frame_start || sclk_rise) begin
        serial_out_oe <= !shift_r[WORD_W-1];
      end
    end
  end

  // ------------------------------------------------------------
  // per-channel registers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          wiper_r[g] <= EEPROM_INIT;
          input_r[g] <= EEPROM_INIT;
        end else if (exec) begin
          case (cmd_ctl)
            CMD_WR_WIPER: begin
              if (cmd_mask[g]) begin
                wiper_r[g] <= cmd_dat;
                input_r[g] <= cmd_dat;
              end
            end
            CMD_WR_INPUT: begin
              if (cmd_mask[g]) begin
                input_r[g] <= cmd_dat;
              end
            end
            CMD_COPY: begin
              if (cmd_mask[g] && !cmd_opt) begin
                wiper_r[g] <= eeprom_r[g];
                input_r[g] <= eeprom_r[g];
              end
            end
            CMD_SW_RESET: begin
              wiper_r[g] <= eeprom_r[g];
              input_r[g] <= eeprom_r[g];
            end
            default: begin
              wiper_r[g] <= wiper_r[g];
            end
          endcase
        end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          eeprom_r[g] <= EEPROM_INIT;
        end else if (store_go && cmd_mask[g]) begin
          eeprom_r[g] <= wiper_r[g];
        end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          shdn_r[g] <= 1'b0;
        end else if (exec && cmd_ctl == CMD_SHUTDOWN && cmd_mask[g]) begin
          shdn_r[g] <= cmd_opt;
        end
      end

      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          wiper_setting[g*8 +: 8] <= EEPROM_INIT;
        end else begin
          wiper_setting[g*8 +: 8] <= wiper_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shutdown <= '0;
    end else begin
      shutdown <= shdn_r;
    end
  end

  // ------------------------------------------------------------
  // store lockout timer
  // ------------------------------------------------------------
  logic [STORE_CNT_W-1:0] store_cnt_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      store_st_r <= DPSC_ST_IDLE;
      store_cnt_r <= '0;
    end else begin
      case (store_st_r)
        DPSC_ST_IDLE: begin
          if (store_go) begin
            store_st_r <= DPSC_ST_STORE;
            store_cnt_r <= STORE_CNT_W'(STORE_CNT - 1);
          end
        end
        DPSC_ST_STORE: begin
          if (store_cnt_r == '0) begin
            store_st_r <= DPSC_ST_IDLE;
          end else begin
            store_cnt_r <= store_cnt_r - 1'b1;
          end
        end
        default: begin
          store_st_r <= DPSC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      store_busy <= 1'b0;
    end else begin
      store_busy <= (store_st_r == DPSC_ST_STORE);
    end
  end

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_r <= reg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata <= ctrl_r;
        REG_STATUS: reg_rdata <= {{(7-NCH){1'b0}}, shdn_r,
                                  store_st_r == DPSC_ST_STORE};
        REG_WIPER0: reg_rdata <= wiper_r[0];
        REG_WIPER1: reg_rdata <= wiper_r[NCH-1];
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule

// ### tb/dpsc_port_asserts.sv
// concurrent checks on the serial command port pins
`timescale 1ns/100ps
module dpsc_port_asserts import dpsc_pkg::*; #(
  parameter int NCH = 2,
  parameter int STORE_CNT = STORE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out_od,
  input wire logic serial_out_oe,
  input wire logic [RADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [NCH*8-1:0] wiper_setting,
  input wire logic [NCH-1:0] shutdown,
  input wire logic store_busy
);
  logic [3:0] rise_age_r;
  logic [19:0] busy_len_r;
  wire logic [7:0] wiper_hi = wiper_setting[NCH*8-1 -: 8];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rise_age_r <= 4'hf;
    end else if (!frame_sel_n) begin
      rise_age_r <= 4'h0;
    end else if (rise_age_r != 4'hf) begin
      rise_age_r <= rise_age_r + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_len_r <= 20'h0_0000;
    end else if (!store_busy) begin
      busy_len_r <= 20'h0_0000;
    end else begin
      busy_len_r <= busy_len_r + 20'h0_0001;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  od_low_a: assert property (serial_out_od == 1'b0)
    else $error("serial data value not low");
  oe_idle_a: assert property (frame_sel_n [*5] |-> !serial_out_oe)
    else $error("serial output enabled outside frame");
  oe_hold_a: assert property ((!frame_sel_n && $fell(sclk)) |-> ##2 $stable(serial_out_oe) [*3])
    else $error("serial output moved after clock fall");
  exec_late_a: assert property (($changed(wiper_setting) || $changed(shutdown))
    |-> (rise_age_r >= 4'h1 && rise_age_r <= 4'hc)) else $error("state changed outside execute");
  lock_hold_a: assert property ((store_busy && $past(store_busy)) |-> $stable(wiper_setting))
    else $error("wiper changed during store");
  busy_len_a: assert property ($fell(store_busy) |->
    (busy_len_r >= STORE_CNT - 1 && busy_len_r <= STORE_CNT + 1)) else $error("store time wrong");
  status_rd_a: assert property ((reg_rd && reg_addr == REG_STATUS)
    |=> reg_rdata == {5'h00, shutdown, store_busy}) else $error("status read wrong");
  wiper_rd_a: assert property ((reg_rd && reg_addr == REG_WIPER1)
    |=> reg_rdata == wiper_hi) else $error("wiper read wrong");
  cover property ($rose(store_busy));
  cover property ($rose(shutdown[0]));
  cover property (!frame_sel_n && serial_out_oe);
endmodule
bind dpsc_port dpsc_port_asserts #(.NCH(NCH), .STORE_CNT(STORE_CNT)) dpsc_port_asserts_inst (
  .sys_clk(sys_clk), .nrst(nrst), .frame_sel_n(frame_sel_n), .sclk(sclk), .serial_in(serial_in),
  .serial_out_od(serial_out_od), .serial_out_oe(serial_out_oe), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wiper_setting(wiper_setting), .shutdown(shutdown), .store_busy(store_busy));

// ### tb/dpsc_spi_host.sv
// spi controller model driving the command port pins
`timescale 1ns/100ps
module dpsc_spi_host (
  input wire logic sys_clk,
  input wire logic line_in,
  output logic frame_sel_n,
  output logic sclk,
  output logic serial_in
);
  initial begin
    frame_sel_n = 1'b1;
    sclk = 1'b1;
    serial_in = 1'b0;
  end
  // frame of n bits, msb first; line sampled in the low phase
  task automatic xfer(input int n, input logic [31:0] w, output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(posedge sys_clk);
    frame_sel_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= w[i];
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rx[i] = line_in;
      repeat (2) @(posedge sys_clk);
      sclk <= 1'b1;
    end
    repeat (8) @(posedge sys_clk);
    frame_sel_n <= 1'b1;
    serial_in <= ~serial_in;
    repeat (8) @(posedge sys_clk);
  endtask
endmodule

// ### tb/dpsc_port_test.sv
// self-checking bench for the serial command port
`timescale 1ns/100ps
module dpsc_port_test import dpsc_pkg::*;;
  localparam int STC = 400;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [15:0] wiper_setting;
  logic [1:0] shutdown;
  logic store_busy, serial_out_od, serial_out_oe, frame_sel_n, sclk, serial_in;
  logic [31:0] rx;
  int error_cnt = 0;
  int checked = 0;
  wire logic line = serial_out_oe ? 1'b0 : 1'b1;
  always #20 sys_clk = ~sys_clk;
  dpsc_port #(.NCH(2), .STORE_CNT(STC)) dpsc_port_inst (.sys_clk(sys_clk), .nrst(nrst),
    .frame_sel_n(frame_sel_n), .sclk(sclk), .serial_in(serial_in), .serial_out_od(serial_out_od),
    .serial_out_oe(serial_out_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wiper_setting(wiper_setting),
    .shutdown(shutdown), .store_busy(store_busy));
  dpsc_spi_host dpsc_spi_host_inst (.sys_clk(sys_clk), .line_in(line),
    .frame_sel_n(frame_sel_n), .sclk(sclk), .serial_in(serial_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rw(input logic wr, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= ~wr;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    q = reg_rdata;
  endtask
  task automatic fr(input int n, input logic [31:0] w);
    dpsc_spi_host_inst.xfer(n, w, rx);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [7:0] q;
    chk(wiper_setting, 32'h0000_8080);
    chk({shutdown, store_busy, serial_out_oe}, 32'h0000_0000);
    rw(1'b0, REG_CTRL, 8'h00, q);
    chk(q, 32'h0000_0001);
    rw(1'b0, 3'h5, 8'h00, q);
    chk(q, 32'h0000_0000);
  endtask
  task automatic t_write();
    fr(16, {CMD_WR_WIPER, 4'h0, 8'h3c});
    fr(16, {CMD_WR_WIPER, 4'h1, 8'ha5});
    chk(wiper_setting, 32'h0000_a53c);
    fr(16, {CMD_WR_INPUT, 4'h0, 8'h11});
    chk(rx, 32'h0000_11a5);
    chk(wiper_setting, 32'h0000_a53c);
    fr(16, {CMD_READBACK, 4'h0, 6'h00, RB_INPUT});
    fr(16, {CMD_NOP, 12'hfff});
    chk(rx, 32'h0000_0011);
    fr(16, {CMD_READBACK, 4'h1, 6'h00, RB_WIPER});
    fr(16, {CMD_NOP, 12'hfff});
    chk(rx, 32'h0000_00a5);
    chk(wiper_setting, 32'h0000_a53c);
  endtask
  task automatic t_short();
    fr(15, {CMD_WR_WIPER, 4'h0, 8'h01});
    chk(wiper_setting, 32'h0000_a53c);
    fr(17, {15'h0000, 1'b1, CMD_WR_WIPER, 4'h0, 8'h02});
    chk(wiper_setting, 32'h0000_a53c);
    fr(24, {8'h00, 8'hff, CMD_WR_WIPER, 4'h0, 8'h03});
    chk(wiper_setting, 32'h0000_a503);
    fr(32, {CMD_WR_WIPER, 4'h1, 8'h77, CMD_WR_WIPER, 4'h1, 8'h5a});
    chk(rx, 32'h1003_1177);
    chk(wiper_setting, 32'h0000_5a03);
  endtask
  task automatic t_store();
    fr(16, {CMD_COPY, 4'h0, 8'h01});
    chk(store_busy, 32'h0000_0001);
    fr(16, {CMD_WR_WIPER, 4'h0, 8'h44});
    chk(wiper_setting, 32'h0000_5a03);
    for (int k = 0; k < 1000 && store_busy !== 1'b0; k++) @(posedge sys_clk);
    chk(store_busy, 32'h0000_0000);
    fr(16, {CMD_WR_WIPER, 4'h0, 8'h44});
    chk(wiper_setting, 32'h0000_5a44);
    fr(16, {CMD_COPY, 4'h0, 8'h00});
    chk(wiper_setting, 32'h0000_5a03);
    fr(16, {CMD_READBACK, 4'h0, 6'h00, RB_EEPROM});
    fr(16, {CMD_WR_WIPER, 4'h1, 8'h99});
    chk(rx, 32'h0000_0003);
    fr(16, {CMD_SW_RESET, 12'h000});
    chk(wiper_setting, 32'h0000_8003);
  endtask
  task automatic t_shut();
    logic [7:0] q;
    fr(16, {CMD_SHUTDOWN, 4'h8, 8'h01});
    chk(shutdown, 32'h0000_0003);
    rw(1'b0, REG_STATUS, 8'h00, q);
    chk(q, 32'h0000_0006);
    fr(16, {CMD_SHUTDOWN, 4'h1, 8'h00});
    chk(shutdown, 32'h0000_0001);
    fr(16, {CMD_READBACK, 4'h0, 6'h00, RB_CONTROL});
    fr(16, {CMD_NOP, 12'h000});
    chk(rx, 32'h0000_0001);
    rw(1'b1, REG_CTRL, 8'h00, q);
    fr(16, {CMD_WR_WIPER, 4'h0, 8'h00});
    chk(wiper_setting, 32'h0000_8003);
    rw(1'b1, REG_CTRL, 8'h01, q);
    rw(1'b0, REG_WIPER0, 8'h00, q);
    chk(q, 32'h0000_0003);
    rw(1'b0, REG_WIPER1, 8'h00, q);
    chk(q, 32'h0000_0080);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_reset();
    t_write();
    t_short();
    t_store();
    t_shut();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    conclude();
  end
endmodule
